// ==== core/nlc_defines.vh ====
// constants for the link capability and link control register bank
// assumes a configuration access port with dword address and byte enables
`ifndef NLC_DEFINES_VH
`define NLC_DEFINES_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define NLC_LINK_CAPABILITIES_OFS  12'h04c
`define NLC_LINK_CONTROL_OFS       12'h050

// ****************************************************************
// link capabilities fields
// ****************************************************************
`define NLC_MAX_LINK_SPEED_LSB     0
`define NLC_MAX_LINK_SPEED_MSB     3
`define NLC_MAX_LINK_WIDTH_LSB     4
`define NLC_MAX_LINK_WIDTH_MSB     9
`define NLC_LOWPOWER_SUPPORT_LSB   10
`define NLC_LOWPOWER_SUPPORT_MSB   11
`define NLC_L0S_EXIT_LAT_LSB       12
`define NLC_L0S_EXIT_LAT_MSB       14
`define NLC_L1_EXIT_LAT_LSB        15
`define NLC_L1_EXIT_LAT_MSB        17
`define NLC_PORT_NUMBER_LSB        24
`define NLC_PORT_NUMBER_MSB        31

`define NLC_SPEED_2G5              4'h1
`define NLC_WIDTH_RESET            6'h08
`define NLC_WIDTH_X1               6'h01
`define NLC_WIDTH_X2               6'h02
`define NLC_WIDTH_X4               6'h04
`define NLC_WIDTH_X8               6'h08
`define NLC_LOWPOWER_L0S_ONLY      2'h1
`define NLC_L0S_LAT_SEPARATE       3'h5
`define NLC_L0S_LAT_COMMON         3'h3
`define NLC_L1_LAT_DEEP_DIS        3'h0
`define NLC_L1_LAT_DEFAULT         3'h4
`define NLC_PORT_NUMBER_RESET      8'h02

// ****************************************************************
// link control fields
// ****************************************************************
`define NLC_ASPM_LSB               0
`define NLC_ASPM_MSB               1
`define NLC_RCB_BIT                3
`define NLC_LINK_DISABLE_BIT       4
`define NLC_LINK_RETRAIN_BIT       5
`define NLC_COMMON_CLOCK_BIT       6
`define NLC_EXTENDED_SYNC_BIT      7
`define NLC_ASPM_RESET             2'h0
`define NLC_ASPM_L0S_BIT           0
`define NLC_ASPM_L1_BIT            1

// ****************************************************************
// extended sync ordered set counts
// ****************************************************************
`define NLC_FTS_EXTENDED           13'h1000
`define NLC_FTS_NORMAL             13'h0000

`endif

// ==== core/nlc_link_regs.v ====
// link capability and link control register bank of the non-transparent port
// assumes a single-cycle config access port on the core clock; reads answer next cycle
//
// Functional notes
// (RULE_01) max link speed is read-only and always reads the 2.5 Gbps code.
// (RULE_02) max link width resets to x8 and accepts x1, x2, x4 and x8 to force a narrower link.
// (RULE_03) a zero or other unlisted width code makes the port run as a single lane.
// (RULE_04) power support is read-only and reports L0s only, never L1.
// (RULE_05) with separate clocks the L0s exit latency reads code five.
// (RULE_06) with a common clock the L0s exit latency reads code three.
// (RULE_07) with either deep disable active the L1 exit latency reads zero.
// (RULE_08) with no deep disable active the L1 exit latency reads code four.
// (RULE_09) the port number byte resets to two and reports the port number.
// (RULE_10) the ASPM field resets to disabled; codes mean off, L0s, L1, both.
// (RULE_11) the read completion boundary bit is read-only zero.
// (RULE_12) link disable is read-write and has no effect on operation.
// (RULE_13) writing one to retrain moves the training state machine to Recovery.
// (RULE_14) the retrain bit always reads zero.
// (RULE_15) common clock configuration resets to zero, is read-write, and flags a shared clock.
// (RULE_16) extended sync makes the transmitter send 4096 FTS sets in L0s then one SKP.
// (RULE_17) the L0s latency code follows the common clock configuration bit.
`timescale 1ns/1ps
`include "nlc_defines.vh"
`default_nettype none

module nlc_link_regs (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        cfg_wr_i,
    input  wire        cfg_rd_i,
    input  wire [11:0] cfg_addr_i,
    input  wire [3:0]  cfg_be_i,
    input  wire [31:0] cfg_wdata_i,
    input  wire        deep_d3_disable_i,
    input  wire        deep_l1_disable_i,
    output reg  [31:0] cfg_rdata_o,
    output reg         cfg_ack_o,
    output reg  [5:0]  link_width_o,
    output reg         aspm_l0s_en_o,
    output reg         aspm_l1_en_o,
    output reg         retrain_o,
    output reg         common_clock_o,
    output reg         link_disable_o,
    output reg  [12:0] fts_count_o,
    output reg         skp_after_fts_o
);

    // ****************************************************************
    // storage
    // ****************************************************************
    reg  [5:0]  max_link_width;
    reg  [7:0]  port_number;
    reg  [1:0]  aspm_ctl;
    reg         link_disable;
    reg         common_clock_cfg;
    reg         extended_sync;
    wire [1:0]  deep_raw;
    wire [1:0]  deep_flt;
    wire        deep_d3_q;
    wire        deep_l1_q;

    wire        hit_cap;
    wire        hit_ctl;
    wire        wr_cap;
    wire        wr_ctl;
    wire [11:0] cap_ofs;
    wire [11:0] ctl_ofs;
    reg  [31:0] cap_word;
    reg  [31:0] ctl_word;
    reg  [31:0] next_rdata;
    reg  [5:0]  next_width;

    // dword decode, byte offset bits dropped on purpose
    assign cap_ofs = `NLC_LINK_CAPABILITIES_OFS;
    assign ctl_ofs = `NLC_LINK_CONTROL_OFS;
    assign hit_cap = (cfg_addr_i[11:2] == cap_ofs[11:2]);
    assign hit_ctl = (cfg_addr_i[11:2] == ctl_ofs[11:2]);
    assign wr_cap  = cfg_wr_i & hit_cap;
    assign wr_ctl  = cfg_wr_i & hit_ctl;

    // ****************************************************************
    // deep disable settings come from another block; sync and filter
    // ****************************************************************
    assign deep_raw = {deep_l1_disable_i, deep_d3_disable_i};

    // one three-stage filter per deep disable input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_deep_sync
            reg sync_s1;
            reg sync_s2;
            reg sync_s3;
            reg sync_q;
            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sync_s1 <= 1'b0;
                    sync_s2 <= 1'b0;
                    sync_s3 <= 1'b0;
                    sync_q  <= 1'b0;
                end else begin
                    sync_s1 <= deep_raw[gi];
                    sync_s2 <= sync_s1;
                    sync_s3 <= sync_s2;
                    // change counts once stages two and three agree
                    if (sync_s2 == sync_s3) begin
                        sync_q <= sync_s3;
                    end
                end
            end
            assign deep_flt[gi] = sync_q;
        end
    endgenerate

    assign deep_d3_q = deep_flt[0];
    assign deep_l1_q = deep_flt[1];

    // ****************************************************************
    // capability register writable fields
    // ****************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // (RULE_02) width reset x8
            max_link_width <= `NLC_WIDTH_RESET;
            // (RULE_09) port number reset
            port_number    <= `NLC_PORT_NUMBER_RESET;
        end else if (wr_cap) begin
            if (cfg_be_i[0]) begin
                max_link_width[3:0] <= cfg_wdata_i[7:4];
            end
            if (cfg_be_i[1]) begin
                max_link_width[5:4] <= cfg_wdata_i[9:8];
            end
            // (RULE_09) port number writable
            if (cfg_be_i[3]) begin
                port_number <= cfg_wdata_i[31:24];
            end
        end
    end

    // ****************************************************************
    // control register writable fields, low byte only
    // ****************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // (RULE_10) aspm reset disabled
            aspm_ctl         <= `NLC_ASPM_RESET;
            link_disable     <= 1'b0;
            // (RULE_15) common clock reset zero
            common_clock_cfg <= 1'b0;
            extended_sync    <= 1'b0;
        end else if (wr_ctl && cfg_be_i[0]) begin
            aspm_ctl         <= cfg_wdata_i[`NLC_ASPM_MSB:`NLC_ASPM_LSB];
            // (RULE_12) stored, drives nothing internal
            link_disable     <= cfg_wdata_i[`NLC_LINK_DISABLE_BIT];
            // (RULE_15) common clock writable
            common_clock_cfg <= cfg_wdata_i[`NLC_COMMON_CLOCK_BIT];
            extended_sync    <= cfg_wdata_i[`NLC_EXTENDED_SYNC_BIT];
        end
    end

    // ****************************************************************
    // read words
    // ****************************************************************
    always @* begin
        cap_word = 32'h0000_0000;
        // (RULE_01) hardwired speed code
        cap_word[`NLC_MAX_LINK_SPEED_MSB:`NLC_MAX_LINK_SPEED_LSB] = `NLC_SPEED_2G5;
        cap_word[`NLC_MAX_LINK_WIDTH_MSB:`NLC_MAX_LINK_WIDTH_LSB] = max_link_width;
        // (RULE_04) l0s support only
        cap_word[`NLC_LOWPOWER_SUPPORT_MSB:`NLC_LOWPOWER_SUPPORT_LSB] = `NLC_LOWPOWER_L0S_ONLY;
        // (RULE_05) (RULE_06) (RULE_17) l0s latency by clocking
        cap_word[`NLC_L0S_EXIT_LAT_MSB:`NLC_L0S_EXIT_LAT_LSB] =
            common_clock_cfg ? `NLC_L0S_LAT_COMMON : `NLC_L0S_LAT_SEPARATE;
        // (RULE_07) (RULE_08) l1 latency by deep disables
        cap_word[`NLC_L1_EXIT_LAT_MSB:`NLC_L1_EXIT_LAT_LSB] =
            (deep_d3_q | deep_l1_q) ? `NLC_L1_LAT_DEEP_DIS : `NLC_L1_LAT_DEFAULT;
        cap_word[`NLC_PORT_NUMBER_MSB:`NLC_PORT_NUMBER_LSB] = port_number;

        ctl_word = 32'h0000_0000;
        ctl_word[`NLC_ASPM_MSB:`NLC_ASPM_LSB] = aspm_ctl;
        // (RULE_11) rcb reads zero
        ctl_word[`NLC_RCB_BIT]          = 1'b0;
        ctl_word[`NLC_LINK_DISABLE_BIT] = link_disable;
        // (RULE_14) retrain reads zero
        ctl_word[`NLC_LINK_RETRAIN_BIT] = 1'b0;
        ctl_word[`NLC_COMMON_CLOCK_BIT] = common_clock_cfg;
        ctl_word[`NLC_EXTENDED_SYNC_BIT] = extended_sync;

        if (hit_cap) begin
            next_rdata = cap_word;
        end else if (hit_ctl) begin
            next_rdata = ctl_word;
        end else begin
            next_rdata = 32'h0000_0000; // unmapped reads zero
        end
    end

    // ****************************************************************
    // effective width decode
    // ****************************************************************
    always @* begin
        // (RULE_03) unlisted codes fall back to x1
        case (max_link_width)
            `NLC_WIDTH_X1: next_width = `NLC_WIDTH_X1;
            `NLC_WIDTH_X2: next_width = `NLC_WIDTH_X2;
            `NLC_WIDTH_X4: next_width = `NLC_WIDTH_X4;
            `NLC_WIDTH_X8: next_width = `NLC_WIDTH_X8;
            default:       next_width = `NLC_WIDTH_X1;
        endcase
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_rdata_o     <= 32'h0000_0000;
            cfg_ack_o       <= 1'b0;
            link_width_o    <= `NLC_WIDTH_RESET;
            aspm_l0s_en_o   <= 1'b0;
            aspm_l1_en_o    <= 1'b0;
            retrain_o       <= 1'b0;
            common_clock_o  <= 1'b0;
            link_disable_o  <= 1'b0;
            fts_count_o     <= `NLC_FTS_NORMAL;
            skp_after_fts_o <= 1'b0;
        end else begin
            cfg_ack_o       <= cfg_rd_i | cfg_wr_i;
            cfg_rdata_o     <= cfg_rd_i ? next_rdata : 32'h0000_0000;
            link_width_o    <= next_width;
            // (RULE_10) aspm code decode
            aspm_l0s_en_o   <= aspm_ctl[`NLC_ASPM_L0S_BIT];
            aspm_l1_en_o    <= aspm_ctl[`NLC_ASPM_L1_BIT];
            // (RULE_13) one-cycle recovery request
            retrain_o       <= wr_ctl & cfg_be_i[0] & cfg_wdata_i[`NLC_LINK_RETRAIN_BIT];
            common_clock_o  <= common_clock_cfg;
            link_disable_o  <= link_disable;
            // (RULE_16) extended fts count and skp
            fts_count_o     <= extended_sync ? `NLC_FTS_EXTENDED : `NLC_FTS_NORMAL;
            skp_after_fts_o <= extended_sync;
        end
    end

endmodule // nlc_link_regs

`default_nettype wire

// ==== test/nlc_link_regs_sva.sv ====
// checker for the link register bank ports
// assumes it is bound onto nlc_link_regs
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module nlc_link_regs_sva (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_ack_o,
    input wire logic [5:0]  link_width_o,
    input wire logic        retrain_o,
    input wire logic        common_clock_o,
    input wire logic [12:0] fts_count_o,
    input wire logic        skp_after_fts_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // decoded reads and retrain requests
    wire rd_cap = cfg_rd_i && cfg_addr_i[11:2] == 10'h013;
    wire rd_ctl = cfg_rd_i && cfg_addr_i[11:2] == 10'h014;
    wire rt_req = cfg_wr_i && cfg_addr_i[11:2] == 10'h014 && cfg_be_i[0] && cfg_wdata_i[5];
    a_cap_ro_fields: assert property (rd_cap |=> cfg_ack_o && cfg_rdata_o[3:0] == 4'h1
        && cfg_rdata_o[11:10] == 2'h1) else $error("capability read-only field wrong");
    a_l0s_by_clock: assert property (rd_cap |=>
        cfg_rdata_o[14:12] == (common_clock_o ? 3'h3 : 3'h5)) else $error("l0s latency wrong");
    a_l1_code_set: assert property (rd_cap |=> cfg_rdata_o[17:15] inside {3'h0, 3'h4})
        else $error("l1 latency code wrong");
    a_width_legal: assert property (link_width_o inside {6'h01, 6'h02, 6'h04, 6'h08})
        else $error("illegal effective width");
    a_width_follows: assert property (rd_cap |=> link_width_o ==
        (cfg_rdata_o[9:4] inside {6'h01, 6'h02, 6'h04, 6'h08} ? cfg_rdata_o[9:4] : 6'h01))
        else $error("width does not follow field");
    a_ctl_readback: assert property (rd_ctl |=> cfg_ack_o && cfg_rdata_o[31:8] == 24'h0
        && cfg_rdata_o[5:2] == {1'b0, cfg_rdata_o[4], 2'h0}) else $error("control read-only bits wrong");
    a_retrain_pulse: assert property (rt_req |=> retrain_o) else $error("retrain not pulsed");
    a_retrain_cause: assert property (retrain_o |-> $past(rt_req)) else $error("spurious retrain");
    a_fts_pair: assert property (fts_count_o == (skp_after_fts_o ? 13'h1000 : 13'h0000))
        else $error("fts count and skp disagree");
    c_cap_read: cover property (rd_cap);
    c_retrain: cover property (retrain_o);
    c_ext_sync: cover property (skp_after_fts_o);
endmodule // nlc_link_regs_sva
bind nlc_link_regs nlc_link_regs_sva u_sva (.clk_i, .rstn_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i,
    .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .link_width_o, .retrain_o, .common_clock_o, .fts_count_o,
    .skp_after_fts_o);
`default_nettype wire

// ==== test/nlc_vlink_model.sv ====
// far end of the virtual link: counts recovery entries
// assumes the port's retrain pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
module nlc_vlink_model (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       retrain_i,
    output var  logic [7:0] recover_cnt_o
);
    // each retrain pulse moves the link into recovery once
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            recover_cnt_o <= 8'h00;
        else if (retrain_i)
            recover_cnt_o <= recover_cnt_o + 8'h01;
    end
endmodule // nlc_vlink_model
`default_nettype wire

// ==== test/nlc_link_regs_test.sv ====
// self-checking bench for the link register bank
// assumes design and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module nlc_link_regs_test;
    logic        clk_i = 1'b0, rstn_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
    logic        deep_d3_disable_i = 1'b0, deep_l1_disable_i = 1'b0;
    logic [11:0] cfg_addr_i = 12'h000;
    logic [3:0]  cfg_be_i = 4'h0;
    logic [31:0] cfg_wdata_i = 32'h0, v;
    wire  [31:0] cfg_rdata_o;
    wire  [12:0] fts_count_o;
    wire  [7:0]  rc;
    wire  [5:0]  link_width_o;
    wire         cfg_ack_o, aspm_l0s_en_o, aspm_l1_en_o, retrain_o, common_clock_o, link_disable_o, skp_after_fts_o;
    logic [5:0]  c;
    int          fails = 0, num_checks = 0;
    nlc_link_regs uut (.clk_i, .rstn_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i,
        .deep_d3_disable_i, .deep_l1_disable_i, .cfg_rdata_o, .cfg_ack_o, .link_width_o, .aspm_l0s_en_o,
        .aspm_l1_en_o, .retrain_o, .common_clock_o, .link_disable_o, .fts_count_o, .skp_after_fts_o);
    nlc_vlink_model u_far (.clk_i, .rstn_i, .retrain_i(retrain_o), .recover_cnt_o(rc));
    always #4 clk_i = ~clk_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr32(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge clk_i);
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_be_i = b;
        cfg_wr_i = 1'b1;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task rd32(input logic [11:0] a);
        @(negedge clk_i);
        cfg_addr_i = a;
        cfg_rd_i = 1'b1;
        @(negedge clk_i);
        cfg_rd_i = 1'b0;
        v = cfg_rdata_o;
        chk({31'h0, cfg_ack_o}, 32'h1);
    endtask
    task close_out;
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        close_out;
    end
    initial begin
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        rd32(12'h04c);
        chk(v, 32'h0202_5481);
        rd32(12'h050);
        chk(v, 32'h0);
        rd32(12'h054);
        chk(v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            c = (i < 4) ? 6'h01 << i : 6'h03 * (i - 4);
            wr32(12'h04c, {22'h0, c, 4'hf}, 4'h3);
            rd32(12'h04c);
            chk({26'h0, link_width_o}, (i < 4) ? {26'h0, c} : 32'h1);
            chk({22'h0, v[9:0]}, {22'h0, c, 4'h1});
        end
        wr32(12'h04c, 32'hffff_ffff, 4'h8);
        rd32(12'h04c);
        chk(v, 32'hff02_5431);
        for (int j = 0; j < 4; j++) begin
            wr32(12'h050, j, 4'h1);
            chk({30'h0, aspm_l1_en_o, aspm_l0s_en_o}, j);
        end
        wr32(12'h050, 32'hffff_ffff, 4'hf);
        rd32(12'h050);
        chk(v, 32'h0000_00d3);
        chk({24'h0, rc}, 32'h1);
        chk({29'h0, link_disable_o, common_clock_o, skp_after_fts_o}, 32'h7);
        chk({19'h0, fts_count_o}, 32'h1000);
        rd32(12'h04c);
        chk(v, 32'hff02_3431);
        deep_d3_disable_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rd32(12'h04c);
        chk(v, 32'hff00_3431);
        deep_d3_disable_i = 1'b0;
        deep_l1_disable_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rd32(12'h04c);
        chk(v, 32'hff00_3431);
        deep_l1_disable_i = 1'b0;
        wr32(12'h050, 32'h0, 4'h1);
        rd32(12'h04c);
        chk(v, 32'hff02_5431);
        chk({19'h0, fts_count_o}, 32'h0);
        rstn_i = 1'b0;
        @(negedge clk_i);
        chk({26'h0, link_width_o}, 32'h8);
        rstn_i = 1'b1;
        rd32(12'h04c);
        chk(v, 32'h0202_5481);
        close_out;
    end
endmodule // nlc_link_regs_test
`default_nettype wire
